// >>> dbg_pkg.sv
// Purpose: Shared constants and carriers for the debug serial and trace port
// Assumes: One core clock domain; debug serial clock is sampled, not used as a clock
// Notes: Status codes and frame sizes live here so both design files agree
package dbg_pkg;
    // Status codes that start the strobe clock during reset processing
    localparam logic [3:0] ST_START_C = 4'hc;
    localparam logic [3:0] ST_START_D = 4'hd;
    localparam logic [3:0] ST_HALTED = 4'hf;
    // Serial frame length in bits
    localparam int FRAME_BITS = 17;
    // Reset values
    localparam logic STCLK_DIS_RST = 1'b0;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] TRACE_RST = 4'h0;

    // Trace sample that travels through the buffer
    typedef struct packed {
        logic [3:0] status;
        logic [3:0] trace;
    } dbg_trace_t;

    // Received serial command word and response word
    typedef struct packed {
        logic [16:0] bits;
    } dbg_word_t;
endpackage

// >>> dbg_buf2.sv
// Purpose: Two-entry valid/ready buffer for trace samples
// Assumes: Same clock on both sides
// Notes: Full and empty are exact; a stall downstream pushes back upstream
`timescale 1ns/1ps
module dbg_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];      // Storage
    logic [AW-1:0] wrPtr_reg, wrPtr_next; // Write index
    logic [AW-1:0] rdPtr_reg, rdPtr_next; // Read index
    logic [AW:0] count_reg, count_next;   // Occupancy
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointer and count next values
    always_comb begin
        wrPtr_next = push ? bump(wrPtr_reg) : wrPtr_reg;
        rdPtr_next = pop ? bump(rdPtr_reg) : rdPtr_reg;
        count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Register the pointers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end
endmodule

// >>> dbg_port.sv
// Purpose: Debug serial port and real-time trace outputs of the core
// Assumes: Serial clock and data come from the probe, asynchronous to core_clk
// Notes: The strobe clock is rebuilt from core_clk at half rate, rising mid-sample
`timescale 1ns/1ps

// How it works
// R01: Synchronise serial input, sample after clock high
// R02: Serial output registered, changes after clock validation
// R03: Clock level valid after two equal samples
// R04: Probe keeps serial clock at most strobe/5
// R05: Strobe clock rises mid trace-data window
// R06: Disable bit freezes strobe, status, trace outputs; in DBG_IDLE status and trace still follow the core
// R07: Clearing disable resumes outputs; probe resynchronises
// R08: Strobe idle until status C, D or F
// R09: Four-bit status code synchronous to core clock
// R10: All-ones flag is AND of status bits
// R11: Trace bus carries captured data and breakpoints
// R12: Probe may sample on system clock output
// R13: Halted core shows status F
// R14: Disable bit resets to zero
module dbg_port (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Probe serial pins
    input wire logic debugSerialClock,
    input wire logic debugSerialIn,
    output logic debugSerialOut,
    // Core side
    input wire logic [3:0] coreStatus,
    input wire logic coreHalted,
    input wire logic [3:0] coreTrace,
    input wire logic statusClockDisable,
    // Command delivery to debug logic
    output logic [16:0] cmdWord,
    output logic cmdValid,
    input wire logic [16:0] rspWord,
    // Trace pins
    output logic statusStrobeClock,
    output logic [3:0] coreStatusCode,
    output logic [3:0] traceDataBus,
    output logic statusAllOnesFlag
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: first stage read only by the second
    logic [1:0] sclkSync_reg;  // Serial clock sync chain
    logic [1:0] sdiSync_reg;   // Serial data sync chain
    logic [1:0] disSync_reg;   // Disable bit, crossed as a level
    logic sclkLast_reg, sclkLast_next;     // Previous synced sample
    logic sclkValid_reg, sclkValid_next;   // Validated clock level
    logic [4:0] bitCnt_reg, bitCnt_next;   // Bits shifted this frame
    logic [16:0] shIn_reg, shIn_next;      // Receive shifter
    logic [16:0] shOut_reg, shOut_next;    // Response shifter
    logic sdo_reg, sdo_next;               // Serial out pin register
    logic [16:0] cmd_reg, cmd_next;        // Delivered command
    logic cmdV_reg, cmdV_next;             // Command pulse
    logic sclkRise;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkSync_reg <= 2'h0;
            sdiSync_reg <= 2'h0;
            disSync_reg <= {2{dbg_pkg::STCLK_DIS_RST}}; // [R14]
        end else begin
            sclkSync_reg <= {sclkSync_reg[0], debugSerialClock}; // [R01]
            sdiSync_reg <= {sdiSync_reg[0], debugSerialIn};      // [R01]
            disSync_reg <= {disSync_reg[0], statusClockDisable};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine: level valid when two core edges agree
    assign sclkRise = (sclkSync_reg[1] == sclkLast_reg) && sclkLast_reg && !sclkValid_reg; // [R03]

    always_comb begin
        sclkLast_next = sclkSync_reg[1];
        sclkValid_next = sclkValid_reg;
        if (sclkSync_reg[1] == sclkLast_reg) begin
            sclkValid_next = sclkLast_reg; // [R03]
        end
        bitCnt_next = bitCnt_reg;
        shIn_next = shIn_reg;
        shOut_next = shOut_reg;
        sdo_next = sdo_reg;
        cmd_next = cmd_reg;
        cmdV_next = 1'b0;
        if (sclkRise) begin
            // Data captured only once clock is validated high
            shIn_next = {shIn_reg[15:0], sdiSync_reg[1]}; // [R01]
            // Output changes after validation, from a register
            sdo_next = shOut_reg[16]; // [R02]
            shOut_next = {shOut_reg[15:0], 1'b0};
            if (bitCnt_reg == 5'(dbg_pkg::FRAME_BITS - 1)) begin
                bitCnt_next = 5'h00;
                cmd_next = {shIn_reg[15:0], sdiSync_reg[1]};
                cmdV_next = 1'b1;
                shOut_next = rspWord; // Next frame returns latest response
            end else begin
                bitCnt_next = bitCnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkLast_reg <= 1'b0;
            sclkValid_reg <= 1'b0;
            bitCnt_reg <= 5'h00;
            shIn_reg <= 17'h00000;
            shOut_reg <= 17'h00000;
            sdo_reg <= 1'b0;
            cmd_reg <= 17'h00000;
            cmdV_reg <= 1'b0;
        end else begin
            sclkLast_reg <= sclkLast_next;
            sclkValid_reg <= sclkValid_next;
            bitCnt_reg <= bitCnt_next;
            shIn_reg <= shIn_next;
            shOut_reg <= shOut_next;
            sdo_reg <= sdo_next;
            cmd_reg <= cmd_next;
            cmdV_reg <= cmdV_next;
        end
    end

    assign debugSerialOut = sdo_reg;
    assign cmdWord = cmd_reg;
    assign cmdValid = cmdV_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Trace path: samples pass a two-entry buffer that drains every cycle while the pin stage is frozen
    dbg_pkg::dbg_trace_t samp;
    dbg_pkg::dbg_trace_t bufOut;
    logic bufValid;
    logic bufReady;

    always_comb begin
        samp.status = coreHalted ? dbg_pkg::ST_HALTED : coreStatus; // [R13] [R09]
        samp.trace = coreTrace; // [R11]
    end

    dbg_buf2 #(
        .WIDTH($bits(dbg_pkg::dbg_trace_t)),
        .DEPTH(2)
    ) uBuf (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .inValid(1'b1),
        .inReady(),   // Core never stalls; a full buffer drops the new sample
        .inData(samp),
        .outValid(bufValid),
        .outReady(bufReady),
        .outData(bufOut)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin stage: while running, strobe toggles each core rising edge; data updates on falling phase
    typedef enum logic [1:0] {
        DBG_IDLE = 2'b00,  // Strobe held after reset
        DBG_RUN = 2'b01,   // Strobe toggling
        DBG_QUIET = 2'b10  // Disable bit set
    } dbg_state_t;

    dbg_state_t st_reg, st_next;
    logic strobe_reg, strobe_next;
    logic [3:0] stat_reg, stat_next;
    logic [3:0] trc_reg, trc_next;
    logic all_reg, all_next;

    // Pop one sample per strobe period, at the end of the high phase; the buffer absorbs
    // the gap, and during idle or quiet it pops every cycle: idle shows each sample on the pins, quiet discards them.
    assign bufReady = (st_reg == DBG_RUN) ? strobe_reg : 1'b1;

    always_comb begin
        st_next = st_reg;
        strobe_next = strobe_reg;
        stat_next = stat_reg;
        trc_next = trc_reg;
        all_next = all_reg;
        unique case (st_reg)
            DBG_IDLE: begin
                stat_next = bufValid ? bufOut.status : stat_reg; // [R09]
                trc_next = bufValid ? bufOut.trace : trc_reg;
                all_next = bufValid ? &bufOut.status : all_reg; // [R10]
                if (bufValid && (bufOut.status == dbg_pkg::ST_START_C ||
                        bufOut.status == dbg_pkg::ST_START_D ||
                        bufOut.status == dbg_pkg::ST_HALTED)) begin
                    st_next = disSync_reg[1] ? DBG_QUIET : DBG_RUN; // [R08]
                end
            end
            DBG_RUN: begin
                strobe_next = !strobe_reg; // [R05]
                if (strobe_reg && bufValid) begin
                    // Data moves as strobe falls, so the rise sits mid-window
                    stat_next = bufOut.status; // [R05] [R09]
                    trc_next = bufOut.trace;  // [R11]
                    all_next = &bufOut.status; // [R10]
                end
                if (disSync_reg[1] && strobe_reg) begin
                    st_next = DBG_QUIET; // [R06]
                    strobe_next = 1'b0;
                end
            end
            DBG_QUIET: begin
                // Outputs frozen; breakpoint logic upstream keeps running
                if (!disSync_reg[1]) begin
                    st_next = DBG_RUN; // [R07]
                end
            end
            default: begin
                st_next = DBG_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= DBG_IDLE;
            strobe_reg <= 1'b0;
            stat_reg <= dbg_pkg::STATUS_RST;
            trc_reg <= dbg_pkg::TRACE_RST;
            all_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            strobe_reg <= strobe_next;
            stat_reg <= stat_next;
            trc_reg <= trc_next;
            all_reg <= all_next;
        end
    end

    assign statusStrobeClock = strobe_reg;
    assign coreStatusCode = stat_reg;
    assign traceDataBus = trc_reg;
    assign statusAllOnesFlag = all_reg;
endmodule

// >>> dbg_port_props.sv
// Purpose: Checker for the debug port pins
// Assumes: One core clock domain; windows follow the hand-over timing
// Notes: Bound to every dbg_port instance
`timescale 1ns/1ps
module dbg_port_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Inputs watched
    input wire logic debugSerialClock,
    input wire logic [3:0] coreStatus,
    input wire logic coreHalted,
    input wire logic [3:0] coreTrace,
    input wire logic statusClockDisable,
    // Outputs watched
    input wire logic debugSerialOut,
    input wire logic cmdValid,
    input wire logic statusStrobeClock,
    input wire logic [3:0] coreStatusCode,
    input wire logic [3:0] traceDataBus,
    input wire logic statusAllOnesFlag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Set once a start code has reached the pins
    logic started_reg;
    logic started_next;
    always_comb begin
        started_next = started_reg || (coreStatusCode inside {4'hc, 4'hd, 4'hf});
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= started_next;
        end
    end
    // Core inputs held still long enough to cross the buffer
    sequence steadyIn;
        (coreStatus == $past(coreStatus) && coreTrace == $past(coreTrace)
            && !coreHalted && !statusClockDisable && started_reg) [*8];
    endsequence
    sequence haltRun;
        (coreHalted && !statusClockDisable) [*8];
    endsequence
    chk_allones_and: assert property (statusAllOnesFlag == &coreStatusCode)
        else $error("all-ones flag differs from status AND");
    chk_strobe_idle: assert property (!started_reg |-> !statusStrobeClock)
        else $error("strobe ran before a start code");
    chk_strobe_mid: assert property (statusStrobeClock |-> $stable(coreStatusCode)
        && $stable(traceDataBus))
        else $error("pins moved while strobe high");
    chk_quiet_freeze: assert property (statusClockDisable [*6] |-> $stable(statusStrobeClock)
        && $stable(coreStatusCode) && $stable(traceDataBus))
        else $error("pins toggled while quiet");
    chk_resume_toggle: assert property ($fell(statusClockDisable) && started_reg
        |-> ##[1:12] $changed(statusStrobeClock))
        else $error("strobe did not resume");
    chk_halt_code: assert property (haltRun |-> coreStatusCode == dbg_pkg::ST_HALTED)
        else $error("halted core not shown as F");
    chk_status_follow: assert property (steadyIn |-> coreStatusCode == coreStatus
        && traceDataBus == coreTrace)
        else $error("pins do not follow core");
    chk_serial_valid: assert property ($changed(debugSerialOut) || cmdValid
        |-> $past(debugSerialClock, 2) && $past(debugSerialClock, 3))
        else $error("serial moved without a validated clock high");
    chk_cmd_pulse: assert property (cmdValid |=> !cmdValid)
        else $error("command pulse longer than one cycle");
endmodule
bind dbg_port dbg_port_props CHK (.core_clk(core_clk), .arst_n(arst_n),
    .debugSerialClock(debugSerialClock), .coreStatus(coreStatus), .coreHalted(coreHalted),
    .coreTrace(coreTrace), .statusClockDisable(statusClockDisable),
    .debugSerialOut(debugSerialOut), .cmdValid(cmdValid),
    .statusStrobeClock(statusStrobeClock), .coreStatusCode(coreStatusCode),
    .traceDataBus(traceDataBus), .statusAllOnesFlag(statusAllOnesFlag));

// >>> dbg_probe.sv
// Purpose: Probe model driving the debug serial pins
// Assumes: Serial clock idles low and toggles only inside frames
// Notes: 48 ns period; start a frame between core_clk rising edges so no pin moves on one
`timescale 1ns/1ps
module dbg_probe (
    // Serial pins
    output logic debugSerialClock,
    output logic debugSerialIn,
    input wire logic debugSerialOut
);
    initial begin
        debugSerialClock = 1'b0;
        debugSerialIn = 1'b0;
    end
    // One frame MSB first; reply read late in the low half, after it settled
    task automatic frame(input logic [16:0] cmd, output logic [16:0] rsp);
        for (int i = 16; i >= 0; i--) begin
            debugSerialIn = cmd[i];
            #4.0 debugSerialClock = 1'b1;
            #24.0 debugSerialClock = 1'b0;
            #20.0 rsp[i] = debugSerialOut;
        end
        // Released line shows the inverse so a stale bit cannot pass
        debugSerialIn = ~cmd[0];
    endtask
endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the debug port
// Assumes: Core-side inputs change on the rising edge; serial pins move and outputs are read on the falling one
// Notes: Ordinary trace cases are table rows
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        dbg_pkg::dbg_trace_t in;
        dbg_pkg::dbg_trace_t exp;
    } dbg_row_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic debug_serial_clock, dsIn, dsOut, cmdValid, strobe, allOnes, coreHalted = 1'b0;
    logic statusClockDisable = 1'b0;
    logic heldStrobe;
    logic [3:0] heldTrace;
    logic [3:0] coreStatus = 4'h0, coreTrace = 4'h0, code, trace, heldCode;
    logic [16:0] cmdWord, rsp, rspWord = 17'h00000;
    int n_errors = 0, n_tests = 0, cycles = 0, pulses = 0;
    dbg_row_t rows [6] = '{'{8'hc3, 8'hc3}, '{8'h1a, 8'h1a}, '{8'hd5, 8'hd5},
        '{8'hf0, 8'hf0}, '{8'h7e, 8'h7e}, '{8'h09, 8'h09}};
    always #2.0 core_clk = ~core_clk;
    dbg_probe PRB (.debugSerialClock(debug_serial_clock), .debugSerialIn(dsIn), .debugSerialOut(dsOut));
    dbg_port DUT (.core_clk(core_clk), .arst_n(arst_n), .debugSerialClock(debug_serial_clock),
        .debugSerialIn(dsIn), .debugSerialOut(dsOut), .coreStatus(coreStatus),
        .coreHalted(coreHalted), .coreTrace(coreTrace), .statusClockDisable(statusClockDisable),
        .cmdWord(cmdWord), .cmdValid(cmdValid), .rspWord(rspWord), .statusStrobeClock(strobe),
        .coreStatusCode(code), .traceDataBus(trace), .statusAllOnesFlag(allOnes));
    task automatic report_and_stop();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Cut a hang short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    always @(posedge core_clk) begin
        if (cmdValid === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t nibble %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk17(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        cyc(12);
        chk4({3'h0, strobe}, 4'h0);
        chk4(code, dbg_pkg::STATUS_RST);
        foreach (rows[i]) begin
            @(posedge core_clk);
            coreStatus <= rows[i].in.status;
            coreTrace <= rows[i].in.trace;
            cyc(10);
            chk4(code, rows[i].exp.status);
            chk4(trace, rows[i].exp.trace);
            chk4({3'h0, allOnes}, {3'h0, &rows[i].exp.status});
        end
        @(posedge core_clk);
        coreHalted <= 1'b1;
        cyc(10);
        chk4(code, 4'hf);
        @(posedge core_clk);
        coreHalted <= 1'b0;
        statusClockDisable <= 1'b1;
        cyc(10);
        heldCode = code;
        heldTrace = trace;
        @(posedge core_clk);
        coreStatus <= 4'h5;
        coreTrace <= 4'h6;
        cyc(10);
        chk4(code, heldCode);
        chk4(trace, heldTrace);
        chk4({3'h0, strobe}, 4'h0);
        @(posedge core_clk);
        statusClockDisable <= 1'b0;
        cyc(12);
        chk4(code, 4'h5);
        chk4(trace, 4'h6);
        // Running strobe must flip on each core rising edge
        heldStrobe = strobe;
        cyc(1);
        chk4({3'h0, strobe}, {3'h0, !heldStrobe});
        @(posedge core_clk);
        rspWord <= 17'h15a5a;
        // Serial pins move between core rising edges
        @(negedge core_clk);
        PRB.frame(17'h1a5c3, rsp);
        cyc(8);
        chk17(cmdWord, 17'h1a5c3);
        chk4(pulses[3:0], 4'h1);
        chk17(rsp, 17'h00000);
        PRB.frame(17'h0f0f0, rsp);
        cyc(8);
        chk17(rsp, 17'h15a5a);
        chk17(cmdWord, 17'h0f0f0);
        chk4(pulses[3:0], 4'h2);
        // Mid-run reset, then a non-start code must leave the strobe idle
        @(posedge core_clk);
        arst_n <= 1'b0;
        cyc(3);
        chk4({3'h0, strobe}, 4'h0);
        chk4(code, dbg_pkg::STATUS_RST);
        @(posedge core_clk);
        arst_n <= 1'b1;
        cyc(1);
        chk4(code, dbg_pkg::STATUS_RST);
        cyc(10);
        chk4(code, 4'h5);
        chk4({3'h0, strobe}, 4'h0);
        report_and_stop();
    end
endmodule
